// [logic/aepf_pkg.sv]
// Constants, types and helpers shared by the fault and pin-function register bank.
// Assumes a 50 MHz system clock and an internal oscillator tick of nominally 1 MHz.
`default_nettype none
package aepf_pkg;
  // Register addresses, low nibble of the command byte
  localparam logic [3:0] ADDR_SRST = 4'h1;
  localparam logic [3:0] ADDR_FAULT = 4'h4;
  localparam logic [3:0] ADDR_AUX_DATA = 4'h5;
  localparam logic [3:0] ADDR_SWA = 4'h6;
  localparam logic [3:0] ADDR_SWB = 4'h7;
  localparam logic [3:0] ADDR_DIR = 4'h8;
  localparam logic [3:0] ADDR_SEL = 4'h9;
  localparam logic [3:0] ADDR_CFG1 = 4'ha;
  localparam logic [3:0] ADDR_CFG2 = 4'hb;
  localparam logic [3:0] ADDR_SPECIAL = 4'hc;
  // Command opcodes, high nibble of the command byte
  localparam logic [3:0] OP_READ = 4'h8;
  localparam logic [3:0] OP_WRITE = 4'h4;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SWA = 8'h60;
  localparam logic [7:0] RST_CFG2 = 8'h10;
  // Writable bits per register; other bits read zero, except fault bits 5 and 3, which show live status
  localparam logic [7:0] WM_AUX = 8'h7f;
  localparam logic [7:0] WM_SWA = 8'hff;
  localparam logic [7:0] WM_SWB = 8'hf0;
  localparam logic [7:0] WM_CFG1 = 8'hff;
  localparam logic [7:0] WM_CFG2 = 8'hf9;
  localparam logic [7:0] WM_SPECIAL = 8'hff;
  localparam logic [7:0] FLAG_W1C = 8'hd7;
  // Fault register layout
  localparam int BIT_CHK = 7;
  localparam int BIT_BUF_ON = 5;
  localparam int BIT_FAULT_SUM = 3;
  localparam int BIT_IOV = 0;
  localparam logic [7:0] SRC_MASK = 8'h57;
  // Configuration one and two fields, and the soft restart bit
  localparam int BIT_MUX_OFF = 7;
  localparam int BIT_POL = 5;
  localparam int BIT_DED = 3;
  localparam int BIT_LTD = 7;
  localparam int TIM_MSB = 6;
  localparam int TIM_LSB = 3;
  localparam int BIT_CHKE = 0;
  localparam int BIT_SRST = 0;
  // Special function fields
  localparam int BIT_OSCO = 7;
  localparam int BIT_SYNC = 6;
  localparam int BIT_BSO = 5;
  localparam int BIT_BTI = 4;
  localparam int BIT_EFO = 3;
  localparam int MUX_LINES = 3;
  // Auxiliary pin roles
  localparam int PIN_FAULT = 3;
  localparam int PIN_TRIG = 4;
  localparam int PIN_STAT = 5;
  localparam int PIN_CLK = 6;
  // Timing
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int OSC_PERIOD_NS = 1000;
  localparam int OSC_HALF_CYC = OSC_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam logic [7:0] TRIG_DELAY_TICKS = 8'h03;

  // Buffer activity sequencer
  typedef enum logic [1:0] {BUF_IDLE, BUF_START, BUF_ACTIVE, BUF_HOLD} aepf_buf_t;

  // Suppression code to tick count
  function automatic logic [6:0] aepf_supp_ticks(input logic [3:0] code);
    logic [6:0] n;
    n = {3'h0, code};
    unique case (code)
      4'h9: n = 7'h0c;
      4'ha: n = 7'h10;
      4'hb: n = 7'h18;
      4'hc: n = 7'h20;
      4'hd: n = 7'h30;
      4'he: n = 7'h40;
      4'hf: n = 7'h7f;
      default: n = {3'h0, code};
    endcase
    return n;
  endfunction
endpackage
`default_nettype wire

// [logic/aepf_qual.sv]
// Per-source fault qualifier: a condition must hold for a set number of ticks.
// Assumes the condition and the tick are on the system clock.
`timescale 1ns/1ns
`default_nettype none
module aepf_qual
  import aepf_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  // Qualification
  input wire logic tick_i,
  input wire logic cond_i,
  input wire logic [6:0] limit_i,
  output logic qual_o
);
  logic [6:0] cnt_ff;

  // Counts ticks while the condition stays present
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || (ce_i && clr_i)) begin
      cnt_ff <= '0;
    end else if (ce_i) begin
      if (!cond_i) begin
        cnt_ff <= '0;
      end else if (tick_i && (cnt_ff < limit_i)) begin
        cnt_ff <= cnt_ff + 7'h01;
      end
    end
  end

  // Qualified once the delay has passed
  assign qual_o = cond_i && (cnt_ff >= limit_i);
endmodule // aepf_qual
`default_nettype wire

// [logic/aepf_regs.sv]
// Fault flags, auxiliary pin and special function register bank.
// Assumes a framer on the same clock delivers decoded command and data bytes.
`timescale 1ns/1ns
`default_nettype none
module aepf_regs
  import aepf_pkg::*;
(
  // Clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Command port from the framer
  input wire logic CMD_VALID_I,
  input wire logic [7:0] CMD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic CHK_OK_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  // Raw analog fault conditions at fault register positions
  input wire logic [7:0] FAULT_RAW_I,
  // Gain register mux field
  input wire logic [2:0] GAIN_MUX_I,
  // Auxiliary pins
  input wire logic [6:0] AUX_PIN_I,
  output logic [6:0] AUX_PIN_O,
  output logic [6:0] AUX_PIN_OE_O,
  // Status and analog controls
  output logic BUF_ACTIVE_O,
  output logic COMBINED_FAULT_O,
  output logic [7:0] SWITCH_A_O,
  output logic [7:0] SWITCH_B_O
);
  logic [7:0] flags_ff, aux_data_ff, sw_a_ff, sw_b_ff, dir_ff, sel_ff;
  logic [7:0] cfg1_ff, cfg2_ff, special_ff, nxt_flags, raw8, qual, w1c;
  logic [6:0] aux_s1_ff, aux_s2_ff, aux_s3_ff, nxt_pin, supp;
  logic [7:0] raw_s1_ff, raw_s2_ff, buf_cnt_ff, hold_len, rd_mux, fault_view;
  logic [4:0] osc_div_ff;
  logic osc_ff, int_tick, ext_tick, tick, use_ext, trig, trig_prev, trig_rise;
  logic acc_ok, chk_evt, en_bad, wr_ok, rd_ok, srst, det_en, combined, buf_on;
  logic [3:0] addr;
  aepf_buf_t buf_st_ff;

  // Two-stage synchronisers for pins and analog conditions
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      aux_s1_ff <= '0;
      aux_s2_ff <= '0;
      aux_s3_ff <= '0;
      raw_s1_ff <= '0;
      raw_s2_ff <= '0;
    end else if (CE_I) begin
      aux_s1_ff <= AUX_PIN_I;
      aux_s2_ff <= aux_s1_ff;
      aux_s3_ff <= aux_s2_ff;
      raw_s1_ff <= FAULT_RAW_I;
      raw_s2_ff <= raw_s1_ff;
    end
  end

  // Command decode and checksum gating
  assign addr = CMD_I[3:0];
  assign acc_ok = CMD_VALID_I && (!cfg2_ff[BIT_CHKE] || CHK_OK_I);
  assign chk_evt = CMD_VALID_I && cfg2_ff[BIT_CHKE] && !CHK_OK_I;
  assign en_bad = (addr == ADDR_CFG2) && WDATA_I[BIT_CHKE] && !CHK_OK_I;
  assign wr_ok = acc_ok && (CMD_I[7:4] == OP_WRITE) && !en_bad;
  assign rd_ok = acc_ok && (CMD_I[7:4] == OP_READ);
  assign srst = wr_ok && (addr == ADDR_SRST) && WDATA_I[BIT_SRST];

  // Control registers
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || (CE_I && srst)) begin
      aux_data_ff <= RST_ZERO;
      sw_a_ff <= RST_SWA;
      sw_b_ff <= RST_ZERO;
      dir_ff <= RST_ZERO;
      sel_ff <= RST_ZERO;
      cfg1_ff <= RST_ZERO;
      cfg2_ff <= RST_CFG2;
      special_ff <= RST_ZERO;
    end else if (CE_I && wr_ok) begin
      unique case (addr)
        ADDR_AUX_DATA: aux_data_ff <= WDATA_I & WM_AUX;
        ADDR_SWA: sw_a_ff <= WDATA_I & WM_SWA;
        ADDR_SWB: sw_b_ff <= WDATA_I & WM_SWB;
        ADDR_DIR: dir_ff <= WDATA_I & WM_AUX;
        ADDR_SEL: sel_ff <= WDATA_I & WM_AUX;
        ADDR_CFG1: cfg1_ff <= WDATA_I & WM_CFG1;
        ADDR_CFG2: cfg2_ff <= WDATA_I & WM_CFG2;
        ADDR_SPECIAL: special_ff <= WDATA_I & WM_SPECIAL;
        default: ;
      endcase
    end
  end

  // Internal oscillator divider
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      osc_div_ff <= '0;
      osc_ff <= 1'b0;
    end else if (CE_I) begin
      if (osc_div_ff == 5'(OSC_HALF_CYC - 1)) begin
        osc_div_ff <= '0;
        osc_ff <= !osc_ff;
      end else begin
        osc_div_ff <= osc_div_ff + 5'h01;
      end
    end
  end
  assign int_tick = (osc_div_ff == 5'(OSC_HALF_CYC - 1)) && !osc_ff;
  assign ext_tick = aux_s2_ff[PIN_CLK] && !aux_s3_ff[PIN_CLK];
  assign use_ext = special_ff[BIT_SYNC] && !dir_ff[PIN_CLK];
  assign tick = use_ext ? ext_tick : int_tick;

  assign supp = aepf_supp_ticks(cfg2_ff[TIM_MSB:TIM_LSB]);
  assign hold_len = TRIG_DELAY_TICKS + {1'b0, supp};
  assign trig = special_ff[BIT_BTI] && !dir_ff[PIN_TRIG] && aux_s2_ff[PIN_TRIG];
  assign trig_prev = special_ff[BIT_BTI] && !dir_ff[PIN_TRIG] && aux_s3_ff[PIN_TRIG];
  assign trig_rise = trig && !trig_prev;

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || (CE_I && srst)) begin
      buf_st_ff <= BUF_IDLE;
      buf_cnt_ff <= '0;
    end else if (CE_I) begin
      unique case (buf_st_ff)
        BUF_IDLE: begin
          if (trig_rise) begin
            buf_st_ff <= BUF_START;
            buf_cnt_ff <= '0;
          end
        end
        BUF_START: begin
          if (tick) begin
            if (buf_cnt_ff == TRIG_DELAY_TICKS - 8'h01) begin
              buf_st_ff <= BUF_ACTIVE;
            end
            buf_cnt_ff <= buf_cnt_ff + 8'h01;
          end
        end
        BUF_ACTIVE: begin
          if (!trig) begin
            buf_st_ff <= BUF_HOLD;
            buf_cnt_ff <= '0;
          end
        end
        BUF_HOLD: begin
          if (trig) begin
            buf_st_ff <= BUF_ACTIVE;
          end else if (buf_cnt_ff >= hold_len) begin
            buf_st_ff <= BUF_IDLE;
          end else if (tick) begin
            buf_cnt_ff <= buf_cnt_ff + 8'h01;
          end
        end
      endcase
    end
  end
  assign buf_on = (buf_st_ff == BUF_ACTIVE) || (buf_st_ff == BUF_HOLD);
  assign det_en = !buf_on || cfg1_ff[BIT_DED];
  assign raw8 = raw_s2_ff & SRC_MASK;
  // per-source delay restarts with the event or the buffer end
  for (genvar g = 0; g < 8; g++) begin : g_src
    if (SRC_MASK[g]) begin : g_on
      aepf_qual u_qual (
        .clk_i(SYS_CLK_I),
        .rst_n_i(NRST_I),
        .ce_i(CE_I),
        .clr_i(srst),
        .tick_i(tick),
        .cond_i(raw8[g] && det_en),
        .limit_i(supp),
        .qual_o(qual[g])
      );
    end else begin : g_off
      assign qual[g] = 1'b0;
    end
  end
  assign w1c = (wr_ok && (addr == ADDR_FAULT)) ? (WDATA_I & FLAG_W1C) : RST_ZERO;
  always_comb begin
    if (cfg2_ff[BIT_LTD]) begin
      nxt_flags = qual & SRC_MASK;
    end else begin
      nxt_flags = ((flags_ff & ~w1c) | qual) & SRC_MASK;
    end
    nxt_flags[BIT_CHK] = (flags_ff[BIT_CHK] && !w1c[BIT_CHK]) || chk_evt;
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I || (CE_I && srst && !chk_evt)) begin
      flags_ff <= RST_ZERO;
    end else if (CE_I) begin
      flags_ff <= nxt_flags;
    end
  end
  assign combined = (|(flags_ff & SRC_MASK & ~cfg1_ff)) || flags_ff[BIT_CHK];
  // live buffer bit in the fault view
  always_comb begin
    fault_view = flags_ff;
    fault_view[BIT_BUF_ON] = buf_on;
    fault_view[BIT_FAULT_SUM] = combined;
  end
  // inputs read the pin, outputs read stored data
  always_comb begin
    unique case (addr)
      ADDR_FAULT: rd_mux = fault_view;
      ADDR_AUX_DATA: rd_mux = {1'b0, (aux_data_ff[6:0] & dir_ff[6:0]) |
                                     (aux_s2_ff & ~dir_ff[6:0])};
      ADDR_SWA: rd_mux = sw_a_ff;
      ADDR_SWB: rd_mux = sw_b_ff;
      ADDR_DIR: rd_mux = dir_ff;
      ADDR_SEL: rd_mux = sel_ff;
      ADDR_CFG1: rd_mux = cfg1_ff;
      ADDR_CFG2: rd_mux = cfg2_ff;
      ADDR_SPECIAL: rd_mux = special_ff;
      default: rd_mux = RST_ZERO;
    endcase
  end
  // Read answer one cycle after the command
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      RDATA_O <= '0;
      RVALID_O <= 1'b0;
    end else if (CE_I) begin
      RVALID_O <= rd_ok;
      if (rd_ok) begin
        RDATA_O <= rd_mux;
      end
    end
  end
  // Pin function multiplexer
  always_comb begin
    nxt_pin = aux_data_ff[6:0];
    // mux lines from the gain field
    // lines 0 to 2 on pins 0 to 2
    for (int i = 0; i < MUX_LINES; i++) begin
      if (special_ff[i] && !cfg1_ff[BIT_MUX_OFF]) begin
        nxt_pin[i] = GAIN_MUX_I[i];
      end
    end
    if (special_ff[BIT_EFO]) begin
      nxt_pin[PIN_FAULT] = combined;
    end
    if (special_ff[BIT_BSO]) begin
      nxt_pin[PIN_STAT] = buf_on ^ cfg1_ff[BIT_POL];
    end
    if (special_ff[BIT_OSCO]) begin
      nxt_pin[PIN_CLK] = osc_ff;
    end
  end
  // Registered pin and status outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      AUX_PIN_O <= '0;
      AUX_PIN_OE_O <= '0;
      BUF_ACTIVE_O <= 1'b0;
      COMBINED_FAULT_O <= 1'b0;
      SWITCH_A_O <= RST_SWA;
      SWITCH_B_O <= RST_ZERO;
    end else if (CE_I) begin
      AUX_PIN_O <= nxt_pin;
      AUX_PIN_OE_O <= dir_ff[6:0];
      BUF_ACTIVE_O <= buf_on;
      COMBINED_FAULT_O <= combined;
      SWITCH_A_O <= sw_a_ff;
      SWITCH_B_O <= sw_b_ff;
    end
  end
  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_write(logic [3:0] a);
    CE_I && CMD_VALID_I && (CMD_I == {OP_WRITE, a});
  endsequence
  sequence s_read(logic [3:0] a);
    CE_I && rd_ok && (addr == a);
  endsequence
  chk_dir_reset: assert property (
    $rose(NRST_I) |-> (dir_ff == RST_ZERO) && (AUX_PIN_OE_O == 7'h00))
    else $error("pins not inputs after reset");
  chk_flag_sticky: assert property (
    CE_I && flags_ff[BIT_IOV] && !cfg2_ff[BIT_LTD] && !w1c[BIT_IOV] && !srst
    |=> flags_ff[BIT_IOV])
    else $error("fault flag lost without clear");
  chk_flag_clear: assert property (
    s_write(ADDR_FAULT) ##0 (wr_ok && WDATA_I[BIT_IOV] && !qual[BIT_IOV])
    |=> !flags_ff[BIT_IOV])
    else $error("fault flag not cleared by write one");
  chk_oe_follow: assert property (
    CE_I |=> AUX_PIN_OE_O == $past(dir_ff[6:0]))
    else $error("output enable does not follow direction");
  chk_fault_pin: assert property (
    CE_I && special_ff[BIT_EFO] |=> AUX_PIN_O[PIN_FAULT] == $past(combined))
    else $error("fault pin not driven by combined fault");
  chk_mask_gate: assert property (
    CE_I && ((flags_ff & SRC_MASK & ~cfg1_ff) == 8'h00) && !flags_ff[BIT_CHK]
    |=> !COMBINED_FAULT_O)
    else $error("masked source reached combined fault");
  chk_enable_guard: assert property (
    s_write(ADDR_CFG2) ##0 (WDATA_I[BIT_CHKE] && !CHK_OK_I && !cfg2_ff[BIT_CHKE])
    |=> !cfg2_ff[BIT_CHKE])
    else $error("checksum mode enabled without valid checksum");
  chk_mode_block: assert property (
    CE_I && cfg2_ff[BIT_CHKE] && CMD_VALID_I && !CHK_OK_I
    |=> $stable(dir_ff) && flags_ff[BIT_CHK])
    else $error("bad checksum transaction accepted");
  chk_soft_rst: assert property (
    s_write(ADDR_SRST) ##0 (WDATA_I[BIT_SRST] && acc_ok)
    |=> (dir_ff == RST_ZERO) && (sw_a_ff == RST_SWA) && !cfg2_ff[BIT_CHKE])
    else $error("soft restart did not restore defaults");
  chk_read_dir: assert property (
    s_read(ADDR_DIR) |=> RVALID_O && (RDATA_O == $past(dir_ff)))
    else $error("direction read back wrong");
  chk_trig_delay: assert property (
    CE_I && (buf_st_ff == BUF_IDLE) && trig_rise |=> !buf_on [*8])
    else $error("buffer started before trigger delay");
endmodule // aepf_regs
`default_nettype wire

// [test/aepf_host_model.sv]
// Host side of the command port: issues one transaction at a time.
// Assumes the block answers reads on the same edge that takes the command.
`timescale 1ns/1ns
`default_nettype none
module aepf_host_model
  import aepf_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Command side
  output logic valid_o,
  output logic [7:0] cmd_o,
  output logic [7:0] wdata_o,
  output logic chk_ok_o,
  // Answer side
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i
);
  // Idle command port
  initial begin
    valid_o = 1'b0;
    cmd_o = 8'h00;
    wdata_o = 8'h00;
    chk_ok_o = 1'b0;
  end

  // opcode plus address, checksum verdict alongside
  task automatic xfer(input logic [3:0] op, input logic [3:0] addr, input logic [7:0] data,
                      input logic ok, output logic got, output logic [7:0] rd);
    @(negedge clk_i);
    valid_o = 1'b1;
    cmd_o = {op, addr};
    wdata_o = data;
    chk_ok_o = ok;
    @(negedge clk_i);
    got = rvalid_i;
    rd = rdata_i;
    valid_o = 1'b0;
    // Released lines must not keep their last value
    cmd_o = ~cmd_o;
    wdata_o = ~wdata_o;
  endtask
endmodule // aepf_host_model
`default_nettype wire

// [test/test_amp_error_and_pin_function_regs.sv]
// Self-checking bench for the fault and pin-function register bank.
// Assumes the host model drives the command port and the bench drives pins.
`timescale 1ns/1ns
`default_nettype none
module test_amp_error_and_pin_function_regs;
  import aepf_pkg::*;
  logic sys_clk, nrst, cmd_valid, chk_ok, rvalid, buf_act, comb, lclk, lclk_on, g, ce;
  logic [7:0] cmd, wdata, rdata, fault_raw, sw_a, sw_b, r;
  logic [2:0] gain_mux;
  logic [5:0] aux_drv;
  logic [6:0] aux_in, aux_out, aux_oe;
  int err_total, cmp_count;
  logic [7:0] rst_tab [0:8] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};

  // Pin 6 carries the link clock only while enabled
  assign aux_in = {lclk_on & lclk, aux_drv};

  aepf_host_model u_host (.clk_i(sys_clk), .valid_o(cmd_valid), .cmd_o(cmd), .wdata_o(wdata),
    .chk_ok_o(chk_ok), .rvalid_i(rvalid), .rdata_i(rdata));

  aepf_regs u_dut (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .CE_I(ce), .CMD_VALID_I(cmd_valid),
    .CMD_I(cmd), .WDATA_I(wdata), .CHK_OK_I(chk_ok), .RDATA_O(rdata), .RVALID_O(rvalid),
    .FAULT_RAW_I(fault_raw), .GAIN_MUX_I(gain_mux), .AUX_PIN_I(aux_in), .AUX_PIN_O(aux_out),
    .AUX_PIN_OE_O(aux_oe), .BUF_ACTIVE_O(buf_act), .COMBINED_FAULT_O(comb),
    .SWITCH_A_O(sw_a), .SWITCH_B_O(sw_b));

  // System clock, 50 MHz
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Link clock, 160 ns, phase unrelated to the system clock
  initial begin
    lclk = 1'b0;
    #3;
    forever #80 lclk = ~lclk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic ok = 1'b1);
    logic gg;
    logic [7:0] rr;
    u_host.xfer(OP_WRITE, a, d, ok, gg, rr);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic gg;
    logic [7:0] rr;
    u_host.xfer(OP_READ, a, 8'h00, 1'b1, gg, rr);
    chk({7'h00, gg}, 8'h01);
    chk(rr, exp);
  endtask

  // Bounded wait for a level, then compare
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(negedge sys_clk);
    chk({7'h00, s}, {7'h00, v});
  endtask

  task automatic check_defaults();
    for (int a = 4; a <= 12; a++) rd(a[3:0], rst_tab[a-4]);
    rd(4'he, 8'h00);
    chk(sw_a, RST_SWA);
    chk({1'b0, aux_oe}, 8'h00);
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    fault_raw = 8'h00;
    gain_mux = 3'h0;
    aux_drv = 6'h00;
    lclk_on = 1'b0;
    ce = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    check_defaults();
    // Enable low freezes the bank: the write is not taken
    ce = 1'b0;
    wr(ADDR_SWB, 8'hf0);
    ce = 1'b1;
    rd(ADDR_SWB, 8'h00);
    // Writable masks, then soft restart
    wr(ADDR_SWA, 8'hff);
    wr(ADDR_SWB, 8'hff);
    wr(ADDR_CFG1, 8'hff);
    wr(ADDR_CFG2, 8'hf8);
    wr(ADDR_SPECIAL, 8'hff);
    rd(ADDR_SWA, 8'hff);
    rd(ADDR_SWB, 8'hf0);
    rd(ADDR_CFG1, 8'hff);
    rd(ADDR_CFG2, 8'hf8);
    rd(ADDR_SPECIAL, 8'hff);
    chk(sw_b, 8'hf0);
    wr(ADDR_SRST, 8'h01);
    check_defaults();
    // Mixed directions on the auxiliary pins
    aux_drv = 6'h2a;
    wr(ADDR_DIR, 8'h0f);
    wr(ADDR_AUX_DATA, 8'h55);
    rd(ADDR_AUX_DATA, 8'h25);
    chk({4'h0, aux_out[3:0]}, 8'h05);
    chk({1'b0, aux_oe}, 8'h0f);
    // Mux lines onto pins 0..2, then disabled
    gain_mux = 3'h5;
    wr(ADDR_SPECIAL, 8'h07);
    wr(ADDR_DIR, 8'h07);
    wr(ADDR_AUX_DATA, 8'h02);
    repeat (2) @(negedge sys_clk);
    chk({5'h00, aux_out[2:0]}, 8'h05);
    wr(ADDR_CFG1, 8'h80);
    repeat (2) @(negedge sys_clk);
    chk({5'h00, aux_out[2:0]}, 8'h02);
    // Oscillator out on pin 6 flips once per half period
    wr(ADDR_DIR, 8'h40);
    wr(ADDR_SPECIAL, 8'h80);
    repeat (2) @(negedge sys_clk);
    r = {7'h00, aux_out[6]};
    repeat (OSC_HALF_CYC) @(negedge sys_clk);
    chk({7'h00, aux_out[6]}, r ^ 8'h01);
    chk({1'b0, aux_oe}, 8'h40);
    wr(ADDR_SRST, 8'h01);
    // Latched fault on the link clock tick, shown on pin 3
    aux_drv = 6'h00;
    wr(ADDR_DIR, 8'h08);
    wr(ADDR_SPECIAL, 8'h48);
    lclk_on = 1'b1;
    fault_raw = 8'h01;
    repeat (6) @(negedge sys_clk);
    chk({7'h00, comb}, 8'h00);
    wait_lvl(comb, 1'b1, 100);
    chk({7'h00, aux_out[3]}, 8'h01);
    fault_raw = 8'h00;
    repeat (20) @(negedge sys_clk);
    rd(ADDR_FAULT, 8'h09);
    wr(ADDR_FAULT, 8'h01);
    rd(ADDR_FAULT, 8'h00);
    wait_lvl(comb, 1'b0, 5);
    // Masked source still flags but stays out of the combined fault
    wr(ADDR_CFG1, 8'h01);
    fault_raw = 8'h01;
    repeat (60) @(negedge sys_clk);
    rd(ADDR_FAULT, 8'h01);
    chk({7'h00, comb}, 8'h00);
    fault_raw = 8'h00;
    // Let the released condition pass the synchronisers before clearing
    repeat (4) @(negedge sys_clk);
    wr(ADDR_FAULT, 8'h01);
    rd(ADDR_FAULT, 8'h00);
    wr(ADDR_CFG1, 8'h00);
    // Suppression code 1001 holds twelve ticks
    wr(ADDR_CFG2, 8'h48);
    fault_raw = 8'h10;
    repeat (80) @(negedge sys_clk);
    chk({7'h00, comb}, 8'h00);
    wait_lvl(comb, 1'b1, 60);
    fault_raw = 8'h00;
    // No-latch mode, old flags cleared by the host
    wr(ADDR_CFG2, 8'h90);
    wr(ADDR_FAULT, 8'hff);
    fault_raw = 8'h02;
    wait_lvl(comb, 1'b1, 100);
    fault_raw = 8'h00;
    wait_lvl(comb, 1'b0, 100);
    rd(ADDR_FAULT, 8'h00);
    wr(ADDR_SRST, 8'h01);
    // Checksum mode: bad enable dropped, good enable sticks
    wr(ADDR_CFG2, 8'h11, 1'b0);
    rd(ADDR_CFG2, 8'h10);
    wr(ADDR_CFG2, 8'h11);
    rd(ADDR_CFG2, 8'h11);
    u_host.xfer(OP_READ, ADDR_CFG2, 8'h00, 1'b0, g, r);
    chk({7'h00, g}, 8'h00);
    u_host.xfer(OP_WRITE, ADDR_DIR, 8'h7f, 1'b0, g, r);
    rd(ADDR_DIR, 8'h00);
    rd(ADDR_FAULT, 8'h88);
    wr(ADDR_CFG2, 8'h10);
    u_host.xfer(OP_READ, ADDR_CFG2, 8'h00, 1'b0, g, r);
    chk({7'h00, g}, 8'h01);
    wr(ADDR_FAULT, 8'h80);
    // Trigger pin drives the buffer; detection held off meanwhile
    wr(ADDR_DIR, 8'h20);
    wr(ADDR_SPECIAL, 8'h70);
    aux_drv = 6'h10;
    wait_lvl(buf_act, 1'b1, 100);
    repeat (3) @(negedge sys_clk);
    chk({7'h00, aux_out[5]}, 8'h01);
    rd(ADDR_FAULT, 8'h20);
    fault_raw = 8'h04;
    repeat (40) @(negedge sys_clk);
    chk({7'h00, comb}, 8'h00);
    wr(ADDR_CFG1, 8'h20);
    repeat (3) @(negedge sys_clk);
    chk({7'h00, aux_out[5]}, 8'h00);
    aux_drv = 6'h00;
    repeat (20) @(negedge sys_clk);
    chk({7'h00, buf_act}, 8'h01);
    wait_lvl(buf_act, 1'b0, 200);
    wait_lvl(comb, 1'b1, 100);
    fault_raw = 8'h00;
    lclk_on = 1'b0;
    tally_and_finish();
  end
endmodule // test_amp_error_and_pin_function_regs
`default_nettype wire
